// *** design/ipoc_port.sv ***
// Image port output control: registers, flag levels, arbitration and pin stage
//
// Function
// - Polarity bit 0 inverts the data-qualifier output when set.
// - Polarity bit 1 inverts the horizontal reference output when set.
// - Polarity bit 2 inverts the vertical reference output when set.
// - Polarity bit 3 inverts the second flag output when set.
// - Polarity bit 4 inverts the first flag output when set.
// - Arbitration 00 inhibits port data; 01 passes only video.
// - Arbitration 10 passes only text, no timing reference codes.
// - Arbitration 11 passes text and video, text wins when both pending unless text was taken the cycle before.
// - Bits 5 and 4 are top select bits of first and second flag.
// - Almost-empty below 16, 8, 4 words or at zero, codes 00 to 11.
// - Almost-full at 16, 24, 28 or more, or exactly 32 words.
// - Port clock phase: default, half cycle, about 3 ns, or both.
// - Gated clock phase: none, half cycle, about 3 ns, or both.
// - Gated clock phase applies only when gated clock source bit is set.
// - Enable field 00 disables outputs, 01 enables them always.
// - Enable 10 follows tristate pin low, 11 follows it high.
// - Flag source codes: field, task, sliced, low, filled, overflow, full, empty.
`timescale 1ns/1ns
module ipoc_port #(
  parameter int DW = 16
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic link_clk,
  // Register access, subaddress and data
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Neighbour configuration and FIFO state, core domain
  input wire logic [1:0] gp_a_select_low,
  input wire logic [1:0] gp_b_select_low,
  input wire logic gated_clock_source_sel,
  input wire logic [5:0] fifo_level,
  input wire logic fifo_filled,
  input wire logic fifo_overflow,
  // Word sources, port clock domain
  input wire logic vid_valid,
  input wire logic [DW-1:0] vid_data,
  input wire logic txt_valid,
  input wire logic [DW-1:0] txt_data,
  output logic vid_ack,
  output logic txt_ack,
  // Reference and flag sources, port clock domain
  input wire logic h_ref_in,
  input wire logic v_ref_in,
  input wire logic field_id,
  input wire logic task_flag,
  input wire logic sliced_frame,
  // Image port pins
  input wire logic image_tristate_pin,
  output logic [DW-1:0] port_data_out,
  output logic port_data_oe_n,
  output logic data_qualifier_out,
  output logic horiz_ref_out,
  output logic vert_ref_out,
  output logic gp_flag_out_a,
  output logic gp_flag_out_b,
  output logic ref_oe_n,
  // Phase selects to the clock pad delay cells
  output logic [1:0] port_clock_phase,
  output logic [1:0] gated_clock_phase
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (DW != 8 && DW != 16)
  begin : g_bad_dw
    $error("DW must be 8 or 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag source select, shared by both flag outputs
  function automatic logic flag_pick(input logic [2:0] sel, input logic fid,
    input logic tsk, input logic slc, input ipoc_pkg::ipoc_cfg_s c);
    logic r;
    r = 1'b0;
    case (sel)
      3'h0: r = fid;
      3'h1: r = tsk;
      3'h2: r = slc;
      3'h3: r = 1'b0;
      3'h4: r = c.filled;
      3'h5: r = c.ovf;
      3'h6: r = c.af;
      3'h7: r = c.ae;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Output enable decode from mode and synchronised pin
  function automatic logic oe_pick(input logic [1:0] mode, input logic pin);
    logic r;
    r = 1'b0;
    case (mode)
      ipoc_pkg::OE_OFF: r = 1'b0;
      ipoc_pkg::OE_ON: r = 1'b1;
      ipoc_pkg::OE_PIN_LO: r = ~pin;
      ipoc_pkg::OE_PIN_HI: r = pin;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Core domain state
  typedef struct packed {
    logic [7:0] pol;
    logic [7:0] fifo;
    logic [7:0] clk;
    logic tri_s1;
    logic tri_s2;
    logic [7:0] rd;
    ipoc_pkg::ipoc_cfg_s cfg;
    ipoc_pkg::ipoc_cfg_s hold;
    logic req;
    logic ack_s1;
    logic ack_s2;
  } ipoc_core_s;

  ipoc_core_s c_reg;
  ipoc_core_s c_next;
  // Taken-toggle from the port clock domain, read only through ack_s2
  logic link_ack;

  // Register writes, flag levels, readback and the crossing bundle
  always_comb
  begin
    c_next = c_reg;
    if (reg_wr_en)
    begin
      case (reg_addr)
        ipoc_pkg::ADDR_POL: c_next.pol = reg_wr_data;
        ipoc_pkg::ADDR_FIFO: c_next.fifo = reg_wr_data;
        ipoc_pkg::ADDR_CLK: c_next.clk = reg_wr_data;
        default: c_next.pol = c_reg.pol; // Unmapped writes are dropped
      endcase
    end
    // Pin status for readback; only the second stage is read
    c_next.tri_s1 = image_tristate_pin;
    c_next.tri_s2 = c_reg.tri_s1;
    // Almost-empty threshold
    case (c_reg.fifo[ipoc_pkg::EL_LSB +: 2])
      2'h0: c_next.cfg.ae = fifo_level < ipoc_pkg::LVL_16;
      2'h1: c_next.cfg.ae = fifo_level < ipoc_pkg::LVL_8;
      2'h2: c_next.cfg.ae = fifo_level < ipoc_pkg::LVL_4;
      default: c_next.cfg.ae = fifo_level == ipoc_pkg::LVL_0;
    endcase
    // Almost-full threshold
    case (c_reg.fifo[ipoc_pkg::FL_LSB +: 2])
      2'h0: c_next.cfg.af = fifo_level >= ipoc_pkg::LVL_16;
      2'h1: c_next.cfg.af = fifo_level >= ipoc_pkg::LVL_24;
      2'h2: c_next.cfg.af = fifo_level >= ipoc_pkg::LVL_28;
      default: c_next.cfg.af = fifo_level == ipoc_pkg::LVL_32;
    endcase
    c_next.cfg.filled = fifo_filled;
    c_next.cfg.ovf = fifo_overflow;
    c_next.cfg.pol = c_reg.pol[4:0];
    c_next.cfg.arb = c_reg.fifo[ipoc_pkg::ARB_LSB +: 2];
    c_next.cfg.gpa_sel = {c_reg.fifo[ipoc_pkg::GPA_MSB], gp_a_select_low};
    c_next.cfg.gpb_sel = {c_reg.fifo[ipoc_pkg::GPB_MSB], gp_b_select_low};
    c_next.cfg.ck_ph = c_reg.clk[ipoc_pkg::CKPH_LSB +: 2];
    // The gated phase is forced to default unless the gated clock is in use
    c_next.cfg.gc_ph = gated_clock_source_sel ?
      c_reg.clk[ipoc_pkg::GCPH_LSB +: 2] : 2'h0;
    c_next.cfg.oe_mode = c_reg.clk[ipoc_pkg::OE_LSB +: 2];
    // Crossing handshake: a new snapshot is offered only once the last one was taken,
    // so the bundle never changes while the port side may be sampling it
    c_next.ack_s1 = link_ack;
    c_next.ack_s2 = c_reg.ack_s1;
    if (c_reg.ack_s2 == c_reg.req)
    begin
      c_next.hold = c_reg.cfg;
      c_next.req = ~c_reg.req;
    end
    // Readback of the addressed register, status bits are live
    case (reg_addr)
      ipoc_pkg::ADDR_POL: c_next.rd = c_reg.pol;
      ipoc_pkg::ADDR_FIFO: c_next.rd = c_reg.fifo;
      ipoc_pkg::ADDR_CLK: c_next.rd = c_reg.clk;
      ipoc_pkg::ADDR_STAT:
      begin
        c_next.rd = 8'h00;
        c_next.rd[ipoc_pkg::ST_TRI] = c_reg.tri_s2;
        c_next.rd[ipoc_pkg::ST_FIL] = c_reg.cfg.filled;
        c_next.rd[ipoc_pkg::ST_FOV] = c_reg.cfg.ovf;
      end
      default: c_next.rd = 8'h00;
    endcase
  end

  // Core domain registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      c_reg <= '0;
      c_reg.pol <= ipoc_pkg::RST_POL;
      c_reg.fifo <= ipoc_pkg::RST_FIFO;
      c_reg.clk <= ipoc_pkg::RST_CLK;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  assign reg_rd_data = c_reg.rd;

  ////////////////////////////////////////////////////////////////////////////
  // Port clock domain state
  typedef struct packed {
    logic rq_s1;
    logic rq_s2;
    logic rq_d;
    ipoc_pkg::ipoc_cfg_s cfg;
    logic tri_s1;
    logic tri_s2;
    ipoc_pkg::ipoc_src_e src;
    logic [DW-1:0] data;
    logic dq;
    logic h;
    logic v;
    logic gpa;
    logic gpb;
    logic oe_n;
    logic [1:0] ck_ph;
    logic [1:0] gc_ph;
    logic vack;
    logic tack;
  } ipoc_link_s;

  ipoc_link_s l_reg;
  ipoc_link_s l_next;

  // Config arrives as one coherent snapshot; flag bits lag by a few port cycles
  always_comb
  begin
    l_next = l_reg;
    l_next.rq_s1 = c_reg.req;
    l_next.rq_s2 = l_reg.rq_s1;
    l_next.rq_d = l_reg.rq_s2;
    // The snapshot has stood still since its toggle was launched, so it is safe to take
    if (l_reg.rq_s2 != l_reg.rq_d)
    begin
      l_next.cfg = c_reg.hold;
    end
    l_next.tri_s1 = image_tristate_pin;
    l_next.tri_s2 = l_reg.tri_s1;
    // Arbitration; a source acked last cycle is skipped so a held word is not taken twice
    l_next.src = ipoc_pkg::SRC_IDLE;
    if (l_reg.cfg.arb[1] && txt_valid && l_reg.src != ipoc_pkg::SRC_TXT)
    begin
      l_next.src = ipoc_pkg::SRC_TXT;
    end
    else if (l_reg.cfg.arb[0] && vid_valid && l_reg.src != ipoc_pkg::SRC_VID)
    begin
      l_next.src = ipoc_pkg::SRC_VID;
    end
    l_next.vack = l_next.src == ipoc_pkg::SRC_VID;
    l_next.tack = l_next.src == ipoc_pkg::SRC_TXT;
    // Video words carry the timing codes, so text-only mode never emits them
    case (l_next.src)
      ipoc_pkg::SRC_TXT: l_next.data = txt_data;
      ipoc_pkg::SRC_VID: l_next.data = vid_data;
      default: l_next.data = '0;
    endcase
    l_next.dq = (l_next.src != ipoc_pkg::SRC_IDLE) ^ l_reg.cfg.pol[ipoc_pkg::POL_DQ];
    l_next.h = h_ref_in ^ l_reg.cfg.pol[ipoc_pkg::POL_H];
    l_next.v = v_ref_in ^ l_reg.cfg.pol[ipoc_pkg::POL_V];
    l_next.gpa = flag_pick(l_reg.cfg.gpa_sel, field_id, task_flag, sliced_frame,
      l_reg.cfg) ^ l_reg.cfg.pol[ipoc_pkg::POL_GPA];
    l_next.gpb = flag_pick(l_reg.cfg.gpb_sel, field_id, task_flag, sliced_frame,
      l_reg.cfg) ^ l_reg.cfg.pol[ipoc_pkg::POL_GPB];
    l_next.oe_n = ~oe_pick(l_reg.cfg.oe_mode, l_reg.tri_s2);
    l_next.ck_ph = l_reg.cfg.ck_ph;
    l_next.gc_ph = l_reg.cfg.gc_ph;
  end

  // Port clock domain registers
  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      l_reg <= '0;
      l_reg.oe_n <= 1'b1;
      l_reg.src <= ipoc_pkg::SRC_IDLE;
    end
    else
    begin
      l_reg <= l_next;
    end
  end

  // Pin stage, all straight from flops
  assign port_data_out = l_reg.data;
  assign port_data_oe_n = l_reg.oe_n;
  assign ref_oe_n = l_reg.oe_n;
  assign data_qualifier_out = l_reg.dq;
  assign horiz_ref_out = l_reg.h;
  assign vert_ref_out = l_reg.v;
  assign gp_flag_out_a = l_reg.gpa;
  assign gp_flag_out_b = l_reg.gpb;
  assign vid_ack = l_reg.vack;
  assign txt_ack = l_reg.tack;
  // Taken-toggle back to the core side
  assign link_ack = l_reg.rq_d;
  assign port_clock_phase = l_reg.ck_ph;
  assign gated_clock_phase = l_reg.gc_ph;

endmodule

// *** dv/ipoc_capture_model.sv ***
// Partner: capture controller that takes words and drives the tristate pin
`timescale 1ns/1ns
module ipoc_capture_model #(
  parameter int DW = 16
) (
  // Port side
  input wire logic link_clk,
  input wire logic [DW-1:0] port_data_out,
  input wire logic data_qualifier_out,
  input wire logic port_data_oe_n,
  input wire logic qual_inv,
  input wire logic tri_level,
  output logic image_tristate_pin,
  // Capture results
  output logic [7:0] word_count
);
  initial image_tristate_pin = 1'b0;
  initial word_count = 8'h00;
  // Pin moves off the sampling edge so the port sees a clean level
  always @(negedge link_clk) image_tristate_pin <= tri_level;
  // Words count only while driven and qualified; floating data is ignored
  always @(posedge link_clk)
  begin
    if (!port_data_oe_n && (data_qualifier_out ^ qual_inv))
      word_count <= word_count + 8'h01;
  end
endmodule

// *** dv/ipoc_checker.sv ***
// Checker: port relations of the image port output control
`timescale 1ns/1ns
module ipoc_checker #(
  parameter int DW = 16
) (
  // Clocks, reset and register access
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  // Port side
  input wire logic txt_valid,
  input wire logic [DW-1:0] vid_data,
  input wire logic [DW-1:0] txt_data,
  input wire logic vid_ack,
  input wire logic txt_ack,
  input wire logic h_ref_in,
  input wire logic [DW-1:0] port_data_out,
  input wire logic port_data_oe_n,
  input wire logic ref_oe_n,
  input wire logic data_qualifier_out,
  input wire logic horiz_ref_out
);
  logic [7:0] pol_sh, arb_sh, oe_sh;
  logic [6:0] quiet;
  logic settled;
  // 80 core cycles cover the handshake round trip plus the port pipeline
  assign settled = (quiet == 7'h50);
  // Shadows; link checks wait until a write has crossed into the port domain
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {pol_sh, arb_sh, oe_sh} <= 24'h00_0000;
      quiet <= 7'h00;
    end
    else
    begin
      quiet <= reg_wr_en ? 7'h00 : (settled ? quiet : quiet + 7'h01);
      if (reg_wr_en && reg_addr == ipoc_pkg::ADDR_POL) pol_sh <= reg_wr_data;
      if (reg_wr_en && reg_addr == ipoc_pkg::ADDR_FIFO) arb_sh <= reg_wr_data;
      if (reg_wr_en && reg_addr == ipoc_pkg::ADDR_CLK) oe_sh <= reg_wr_data;
    end
  end
  ////////////////////////////////////////
  sequence s_txt_pend;
    settled && arb_sh[7] && txt_valid && !txt_ack;
  endsequence
  pol_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(reg_addr) == ipoc_pkg::ADDR_POL |-> reg_rd_data == $past(pol_sh))
    else $error("polarity readback wrong");
  unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(reg_addr) == 8'h10 |-> reg_rd_data == 8'h00) else $error("unmapped read not zero");
  ack_onehot_a: assert property (@(posedge link_clk) disable iff (!nrst)
    !(vid_ack && txt_ack)) else $error("two acks at once");
  txt_word_a: assert property (@(posedge link_clk) disable iff (!nrst)
    txt_ack |-> port_data_out == $past(txt_data)) else $error("text word wrong");
  vid_word_a: assert property (@(posedge link_clk) disable iff (!nrst)
    vid_ack |-> port_data_out == $past(vid_data)) else $error("video word wrong");
  idle_zero_a: assert property (@(posedge link_clk) disable iff (!nrst)
    !(vid_ack || txt_ack) |-> port_data_out == '0) else $error("idle data not zero");
  text_first_a: assert property (@(posedge link_clk) disable iff (!nrst)
    s_txt_pend |=> !vid_ack) else $error("video passed pending text");
  no_video_a: assert property (@(posedge link_clk) disable iff (!nrst)
    settled && !arb_sh[6] |-> !vid_ack) else $error("video not allowed");
  no_text_a: assert property (@(posedge link_clk) disable iff (!nrst)
    settled && !arb_sh[7] |-> !txt_ack) else $error("text not allowed");
  qual_pol_a: assert property (@(posedge link_clk) disable iff (!nrst)
    settled |-> data_qualifier_out == ((vid_ack || txt_ack) ^ pol_sh[0]))
    else $error("qualifier level wrong");
  href_pol_a: assert property (@(posedge link_clk) disable iff (!nrst)
    settled |-> horiz_ref_out == ($past(h_ref_in) ^ pol_sh[1])) else $error("href wrong");
  off_float_a: assert property (@(posedge link_clk) disable iff (!nrst)
    settled && oe_sh[1:0] == ipoc_pkg::OE_OFF |-> port_data_oe_n && ref_oe_n)
    else $error("port driven while off");
endmodule
bind ipoc_port ipoc_checker #(.DW(DW)) i_chk (.core_clk(core_clk), .nrst(nrst),
  .link_clk(link_clk), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .txt_valid(txt_valid),
  .vid_data(vid_data), .txt_data(txt_data), .vid_ack(vid_ack), .txt_ack(txt_ack),
  .h_ref_in(h_ref_in), .port_data_out(port_data_out), .port_data_oe_n(port_data_oe_n),
  .ref_oe_n(ref_oe_n), .data_qualifier_out(data_qualifier_out),
  .horiz_ref_out(horiz_ref_out));

// *** dv/test_image_port_output_control.sv ***
// Testbench: enable, arbitration, polarity, flag and phase scenarios
`timescale 1ns/1ns
module test_image_port_output_control;
  logic core_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, reg_wr_en = 1'b0, tri_level = 1'b0;
  logic vid_valid = 1'b0, txt_valid = 1'b0, qual_inv = 1'b0, gated_clock_source_sel = 1'b0;
  logic fifo_filled = 1'b1, fifo_overflow = 1'b0, h_ref_in = 1'b1, v_ref_in = 1'b0;
  logic field_id = 1'b1, task_flag = 1'b0, sliced_frame = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data, rd, cnt, cap_count;
  logic [1:0] gp_a_select_low = 2'h0, gp_b_select_low = 2'h0;
  logic [1:0] port_clock_phase, gated_clock_phase;
  logic [5:0] fifo_level = 6'h20;
  logic [5:0] ae_t [4] = '{6'h10, 6'h08, 6'h04, 6'h01};
  logic [5:0] af_t [4] = '{6'h10, 6'h18, 6'h1C, 6'h20};
  logic [15:0] vid_data = 16'h0000, txt_data = 16'h0000, port_data_out;
  logic vid_ack, txt_ack, port_data_oe_n, data_qualifier_out, horiz_ref_out, vert_ref_out;
  logic gp_flag_out_a, gp_flag_out_b, ref_oe_n, image_tristate_pin;
  logic [4:0] pv;
  logic [7:0] tbl = 8'h55;
  int err_count = 0, comparisons = 0;
  ipoc_port #(.DW(16)) i_dut (.core_clk(core_clk), .nrst(nrst), .link_clk(link_clk),
    .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .gp_a_select_low(gp_a_select_low),
    .gp_b_select_low(gp_b_select_low), .gated_clock_source_sel(gated_clock_source_sel),
    .fifo_level(fifo_level), .fifo_filled(fifo_filled), .fifo_overflow(fifo_overflow),
    .vid_valid(vid_valid), .vid_data(vid_data), .txt_valid(txt_valid), .txt_data(txt_data),
    .vid_ack(vid_ack), .txt_ack(txt_ack), .h_ref_in(h_ref_in), .v_ref_in(v_ref_in),
    .field_id(field_id), .task_flag(task_flag), .sliced_frame(sliced_frame),
    .image_tristate_pin(image_tristate_pin), .port_data_out(port_data_out),
    .port_data_oe_n(port_data_oe_n), .data_qualifier_out(data_qualifier_out),
    .horiz_ref_out(horiz_ref_out), .vert_ref_out(vert_ref_out),
    .gp_flag_out_a(gp_flag_out_a), .gp_flag_out_b(gp_flag_out_b), .ref_oe_n(ref_oe_n),
    .port_clock_phase(port_clock_phase), .gated_clock_phase(gated_clock_phase));
  ipoc_capture_model #(.DW(16)) i_cap (.link_clk(link_clk), .port_data_out(port_data_out),
    .data_qualifier_out(data_qualifier_out), .port_data_oe_n(port_data_oe_n),
    .qual_inv(qual_inv), .tri_level(tri_level), .image_tristate_pin(image_tristate_pin),
    .word_count(cap_count));
  ////////////////////////////////////////
  // Clocks; the port clock is offset so no edge meets a core edge
  initial forever #5 core_clk = ~core_clk;
  initial
  begin
    #3;
    forever #40 link_clk = ~link_clk;
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write, then let the setting reach the port pins
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    repeat (12) @(negedge link_clk);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    d = reg_rd_data;
  endtask
  task automatic end_sim;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Reset spans several port clocks so both domains see it
  initial
  begin
    repeat (3) @(negedge link_clk);
    nrst = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rreg(8'h85 + 8'(i), rd);
      chk_reg(rd, 8'h00);
    end
    wreg(8'h10, 8'hFF);
    rreg(8'h10, rd);
    chk_reg(rd, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      tri_level = i[2];
      wreg(ipoc_pkg::ADDR_CLK, {6'h00, i[1:0]});
      chk_pin(port_data_oe_n, !(i[1:0] == 2'h1 || i[1:0] == {1'b1, i[2]}));
      chk_pin(ref_oe_n, !(i[1:0] == 2'h1 || i[1:0] == {1'b1, i[2]}));
    end
    // Status: pin high, filled set, overflow clear
    rreg(ipoc_pkg::ADDR_STAT, rd);
    chk_reg(rd, 8'h60);
    for (int a = 0; a < 4; a++)
    begin
      wreg(ipoc_pkg::ADDR_FIFO, {a[1:0], 6'h00});
      cnt = cap_count;
      txt_valid = 1'b1;
      vid_valid = 1'b1;
      txt_data = 16'h7E00 + 16'(a);
      vid_data = 16'h0C00 + 16'(a);
      @(posedge link_clk);
      #1;
      chk_pin({txt_ack, vid_ack}, {14'h0000, a[1], a == 1});
      chk_pin(port_data_out, a == 0 ? 16'h0000 : a[1] ? txt_data : vid_data);
      @(negedge link_clk);
      txt_valid = 1'b0;
      vid_valid = 1'b0;
      @(negedge link_clk);
      chk_pin(cap_count, cnt + 8'(a != 0));
    end
    gp_a_select_low = 2'h3;
    gp_b_select_low = 2'h3;
    wreg(ipoc_pkg::ADDR_FIFO, 8'h00);
    for (int b = 0; b < 6; b++)
    begin
      pv = 5'h01 << b;
      qual_inv = pv[0];
      wreg(ipoc_pkg::ADDR_POL, {3'h0, pv});
      chk_pin({gp_flag_out_a, gp_flag_out_b, vert_ref_out, horiz_ref_out,
        data_qualifier_out}, {11'h000, pv ^ 5'h02});
    end
    for (int s = 0; s < 8; s++)
    begin
      gp_a_select_low = s[1:0];
      gp_b_select_low = ~s[1:0];
      wreg(ipoc_pkg::ADDR_FIFO, {2'h0, s[2], !s[2], 4'h0});
      chk_pin({gp_flag_out_a, gp_flag_out_b}, {14'h0000, tbl[s], tbl[7-s]});
    end
    gp_a_select_low = 2'h3;
    gp_b_select_low = 2'h2;
    for (int c = 0; c < 4; c++)
    begin
      wreg(ipoc_pkg::ADDR_FIFO, {4'h3, c[1:0], c[1:0]});
      for (int lv = 0; lv < 33; lv++)
      begin
        fifo_level = lv[5:0];
        repeat (10) @(negedge link_clk);
        chk_pin({gp_flag_out_a, gp_flag_out_b},
          {14'h0000, lv[5:0] < ae_t[c], lv[5:0] >= af_t[c]});
      end
    end
    for (int i = 0; i < 32; i++)
    begin
      gated_clock_source_sel = i[4];
      wreg(ipoc_pkg::ADDR_CLK, {i[3:0], 4'h3});
      rreg(ipoc_pkg::ADDR_CLK, rd);
      chk_reg(rd, {i[3:0], 4'h3});
      chk_pin({gated_clock_phase, port_clock_phase},
        {12'h000, i[4] ? i[3:2] : 2'h0, i[1:0]});
    end
    // Reset in mid-run must bring back the disabled port and default registers
    nrst = 1'b0;
    repeat (3) @(negedge link_clk);
    nrst = 1'b1;
    rreg(ipoc_pkg::ADDR_CLK, rd);
    chk_reg(rd, 8'h00);
    chk_pin(port_data_oe_n, 16'h0001);
    wreg(ipoc_pkg::ADDR_CLK, 8'h53);
    chk_pin({gated_clock_phase, port_clock_phase}, 16'h0005);
    end_sim();
  end
  // Watchdog well beyond the expected run of about 170 us
  initial
  begin
    #400000;
    err_count++;
    end_sim();
  end
endmodule

// *** inc/ipoc_pkg.sv ***
// Package: register map, field positions and carriers for the image port output control
package ipoc_pkg;
  // Register subaddresses
  localparam logic [7:0] ADDR_POL = 8'h85;
  localparam logic [7:0] ADDR_FIFO = 8'h86;
  localparam logic [7:0] ADDR_CLK = 8'h87;
  localparam logic [7:0] ADDR_STAT = 8'h8F;
  // Values after reset: port disabled, all defaults
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_FIFO = 8'h00;
  localparam logic [7:0] RST_CLK = 8'h00;
  // Polarity register bit positions
  localparam int POL_DQ = 0;
  localparam int POL_H = 1;
  localparam int POL_V = 2;
  localparam int POL_GPB = 3;
  localparam int POL_GPA = 4;
  // FIFO flag and arbitration register fields
  localparam int EL_LSB = 0;
  localparam int FL_LSB = 2;
  localparam int GPB_MSB = 4;
  localparam int GPA_MSB = 5;
  localparam int ARB_LSB = 6;
  // Clock phase and enable register fields
  localparam int OE_LSB = 0;
  localparam int CKPH_LSB = 4;
  localparam int GCPH_LSB = 6;
  // Status register bit positions
  localparam int ST_FOV = 4;
  localparam int ST_FIL = 5;
  localparam int ST_TRI = 6;
  // FIFO thresholds in double words
  localparam logic [5:0] LVL_0 = 6'h00;
  localparam logic [5:0] LVL_4 = 6'h04;
  localparam logic [5:0] LVL_8 = 6'h08;
  localparam logic [5:0] LVL_16 = 6'h10;
  localparam logic [5:0] LVL_24 = 6'h18;
  localparam logic [5:0] LVL_28 = 6'h1C;
  localparam logic [5:0] LVL_32 = 6'h20;
  // Arbitration codes
  localparam logic [1:0] ARB_OFF = 2'h0;
  localparam logic [1:0] ARB_VID = 2'h1;
  localparam logic [1:0] ARB_TXT = 2'h2;
  localparam logic [1:0] ARB_BOTH = 2'h3;
  // Output enable codes
  localparam logic [1:0] OE_OFF = 2'h0;
  localparam logic [1:0] OE_ON = 2'h1;
  localparam logic [1:0] OE_PIN_LO = 2'h2;
  localparam logic [1:0] OE_PIN_HI = 2'h3;
  // Word source on the port in a given cycle
  typedef enum logic [1:0] {SRC_IDLE, SRC_VID, SRC_TXT} ipoc_src_e;
  // Configuration and flag bundle handed to the port clock domain
  typedef struct packed {
    logic [4:0] pol;
    logic [1:0] arb;
    logic [2:0] gpa_sel;
    logic [2:0] gpb_sel;
    logic [1:0] ck_ph;
    logic [1:0] gc_ph;
    logic [1:0] oe_mode;
    logic ae;
    logic af;
    logic filled;
    logic ovf;
  } ipoc_cfg_s;
endpackage
